// ==== rtl/pmg_fuse_row.sv ====
// protected fuse row and unprotected factory identity area storage
// assumes one word access per cycle from the bus slave; contents are not reset
`timescale 1ns/1ps
`default_nettype none
module pmg_fuse_row
(
   // clock
   input  wire logic                   clk,
   // access
   input  wire pmg_pkg::pmg_acc_s      acc,
   input  wire logic                   test_mode,
   input  wire logic                   rd_id,
   input  wire logic [4:0]             rd_word,
   output logic [31:0]                 rd_data,
   // decoded fuse configuration
   output pmg_pkg::pmg_fuse_cfg_s      cfg,
   output logic                        wr_refused
);
   import pmg_pkg::*;

   // non-volatile contents survive the system reset
   logic [7:0] row_mem [ROW_BYTES] = '{default: 8'h00};
   logic [7:0] id_mem  [ID_BYTES]  = '{default: 8'h00};

   function automatic logic [7:0] guard_byte(input logic [6:0] idx, input logic [7:0] old,
                                             input logic [7:0] nw, input logic tst,
                                             input logic wp);
      if (tst)
         return nw;
      else if (idx < WP_FIRST)
         return old;
      else if (idx < WO_FIRST)
         return wp ? old : nw;
      else if (idx < SEC_FIRST)
         return old | nw;
      else
         return old;
   endfunction

   always_comb
   begin
      cfg.wp_lock   = row_mem[CTL_BYTE][CTL_WP_BIT];
      cfg.card_dis  = row_mem[CTL_BYTE][CTL_CD_BIT];
      cfg.card_feat = row_mem[CFG_BYTE][CFG_FEAT_BIT];
      cfg.delivered = row_mem[CFG_BYTE][CFG_DELIV_BIT];
      cfg.sec_cfg   = row_mem[SECCFG_BYTE];
      wr_refused    = 1'b0;
      for (int l = 0; l < 4; l++)
      begin
         if (acc.wr && !acc.id_sel &&
             guard_byte({acc.word, 2'(l)}, row_mem[{acc.word, 2'(l)}], acc.wdata[8*l +: 8],
                        test_mode, cfg.wp_lock) != acc.wdata[8*l +: 8])
            wr_refused = 1'b1;
      end
      for (int l = 0; l < 4; l++)
      begin
         rd_data[8*l +: 8] = rd_id ? id_mem[{rd_word[2:0], 2'(l)}] : row_mem[{rd_word, 2'(l)}];
      end
   end

   always_ff @(posedge clk)
   begin
      for (int l = 0; l < 4; l++)
      begin
         if (acc.wr && acc.id_sel)
            id_mem[{acc.word[2:0], 2'(l)}] <= acc.wdata[8*l +: 8];
         else if (acc.wr)
            row_mem[{acc.word, 2'(l)}] <= guard_byte({acc.word, 2'(l)}, row_mem[{acc.word, 2'(l)}],
                                                     acc.wdata[8*l +: 8], test_mode, cfg.wp_lock);
      end
      if (acc.wp_set)
         row_mem[CTL_BYTE][CTL_WP_BIT] <= 1'b1;
      if (acc.cd_set && cfg.card_feat)
         row_mem[CTL_BYTE][CTL_CD_BIT] <= 1'b1;
   end
endmodule
`default_nettype wire

// ==== rtl/pmg_mode_ctrl.sv ====
// privileged mode sequencer: boot, test, application start and mode bits
// assumes test_avail already synchronised and fuse config stable at boot
`timescale 1ns/1ps
`default_nettype none
module pmg_mode_ctrl
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // start-up inputs
   input  wire logic                   test_avail,
   input  wire pmg_pkg::pmg_fuse_cfg_s cfg,
   // software clear of the mode bits and cpu events
   input  wire logic                   sw_wr,
   input  wire logic [1:0]             sw_keep,
   input  wire logic                   svec_call,
   input  wire logic                   cvec_call,
   input  wire logic                   exc_entry,
   // state
   output pmg_pkg::pmg_mode_s          st
);
   import pmg_pkg::*;

   typedef struct packed
   {
      pmg_phase_e phase;
      logic [2:0] cnt;
      logic       ssm;
      logic       sm;
   } pmg_mc_s;

   pmg_mc_s s;
   pmg_mc_s next_s;

   always_comb
   begin
      next_s = s;
      case (s.phase)
         PMG_PH_BOOT:
         begin
            // wait for the pin synchroniser to settle before deciding
            next_s.cnt = s.cnt + 3'h1;
            if (s.cnt == BOOT_CYCLES - 3'h1)
            begin
               if (test_avail && !cfg.delivered)
               begin
                  next_s.phase = PMG_PH_TEST;
                  next_s.ssm   = 1'b1;
                  next_s.sm    = 1'b0;
               end
               else if (cfg.card_feat && cfg.card_dis)
               begin
                  next_s.phase = PMG_PH_REFUSED;
                  next_s.ssm   = 1'b0;
                  next_s.sm    = 1'b0;
               end
               else
               begin
                  next_s.phase = PMG_PH_APP;
                  next_s.ssm   = 1'b0;
                  next_s.sm    = 1'b1;
               end
            end
         end
         PMG_PH_TEST, PMG_PH_APP:
         begin
            // no path leads back to boot; only a reset does that
            if (sw_wr)
            begin
               next_s.ssm = s.ssm & sw_keep[0];
               next_s.sm  = s.sm & sw_keep[1];
            end
            // hardware sets are applied last so they win over a clear
            if (cvec_call && s.phase == PMG_PH_APP)
            begin
               next_s.ssm = 1'b1;
            end
            if ((svec_call && !s.ssm && !s.sm) || exc_entry)
            begin
               next_s.sm = 1'b1;
            end
         end
         PMG_PH_REFUSED:
         begin
            next_s.ssm = 1'b0;
            next_s.sm  = 1'b0;
         end
         default:
         begin
            next_s.phase = PMG_PH_BOOT;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s <= '{phase: PMG_PH_BOOT, cnt: 3'h0, ssm: 1'b1, sm: 1'b0};
      end
      else
      begin
         s <= next_s;
      end
   end

   always_comb
   begin
      st.super_mode_bit  = s.ssm;
      st.system_mode_bit = s.sm;
      st.boot_done       = (s.phase != PMG_PH_BOOT);
      st.start_refused   = (s.phase == PMG_PH_REFUSED);
      if (s.phase == PMG_PH_BOOT)
         st.mode = PMG_MODE_BOOT;
      else if (s.phase == PMG_PH_REFUSED)
         st.mode = PMG_MODE_HALTED;
      else if (s.ssm)
         st.mode = (s.phase == PMG_PH_TEST) ? PMG_MODE_TEST : PMG_MODE_CONTACTLESS;
      else if (s.sm)
         st.mode = PMG_MODE_SYSTEM;
      else
         st.mode = PMG_MODE_USER;
   end
endmodule
`default_nettype wire

// ==== rtl/pmg_pkg.sv ====
// privileged mode and fuse row guard: shared constants, types and carriers
// assumes a single core clock domain and a 32-bit ahb-lite register bus
package pmg_pkg;

   // ------------------------------------------------------------
   // register map (byte offsets, low address bits only)
   // ------------------------------------------------------------
   localparam int          ADDR_W           = 10;
   localparam logic [9:0]  OFS_MODE_STATUS  = 10'h000;
   localparam logic [9:0]  OFS_START_STATUS = 10'h004;
   localparam logic [9:0]  OFS_ROW_CTRL     = 10'h008;
   localparam logic [9:0]  OFS_GUARD_STATUS = 10'h00C;
   localparam logic [9:0]  OFS_ROW_BASE     = 10'h100;
   localparam logic [9:0]  OFS_ID_BASE      = 10'h200;

   // ------------------------------------------------------------
   // fuse row layout (byte indices within the 128-byte row)
   // ------------------------------------------------------------
   localparam int          ROW_BYTES   = 128;
   localparam int          ID_BYTES    = 32;
   localparam logic [6:0]  WP_FIRST    = 7'h20;
   localparam logic [6:0]  WO_FIRST    = 7'h30;
   localparam logic [6:0]  SEC_FIRST   = 7'h50;
   localparam logic [6:0]  CTL_BYTE    = 7'h50;
   localparam logic [6:0]  CFG_BYTE    = 7'h51;
   localparam logic [6:0]  SECCFG_BYTE = 7'h52;
   localparam int          CTL_WP_BIT  = 0;
   localparam int          CTL_CD_BIT  = 1;
   localparam int          CFG_FEAT_BIT = 0;
   localparam int          CFG_DELIV_BIT = 1;

   // ------------------------------------------------------------
   // timing and reset values
   // ------------------------------------------------------------
   localparam logic [2:0]  BOOT_CYCLES   = 3'h4;
   localparam logic [31:0] RESET_RDATA   = 32'h0000_0000;
   localparam logic [1:0]  RESET_SYNC    = 2'h0;

   typedef enum logic [2:0]
   {
      PMG_MODE_BOOT        = 3'b000,
      PMG_MODE_TEST        = 3'b001,
      PMG_MODE_SYSTEM      = 3'b010,
      PMG_MODE_USER        = 3'b011,
      PMG_MODE_CONTACTLESS = 3'b100,
      PMG_MODE_HALTED      = 3'b101
   } pmg_mode_e;

   typedef enum logic [1:0]
   {
      PMG_PH_BOOT    = 2'b00,
      PMG_PH_TEST    = 2'b01,
      PMG_PH_APP     = 2'b10,
      PMG_PH_REFUSED = 2'b11
   } pmg_phase_e;

   typedef struct packed
   {
      logic       wp_lock;
      logic       card_dis;
      logic       card_feat;
      logic       delivered;
      logic [7:0] sec_cfg;
   } pmg_fuse_cfg_s;

   typedef struct packed
   {
      logic       super_mode_bit;
      logic       system_mode_bit;
      pmg_mode_e  mode;
      logic       boot_done;
      logic       start_refused;
   } pmg_mode_s;

   typedef struct packed
   {
      logic        wr;
      logic        id_sel;
      logic [4:0]  word;
      logic [31:0] wdata;
      logic        wp_set;
      logic        cd_set;
   } pmg_acc_s;

endpackage

// ==== rtl/pmg_top.sv ====
// privileged mode and fuse row guard, top level with ahb-lite register slave
// assumes a single ahb-lite master on CORE_CLK, word transfers, one slave on the bus
//
// Functional notes
// - every reset starts in the hidden boot mode before any user program.
// - boot moves to test mode when hardware reports factory test available.
// - without factory test, boot moves to system mode and starts the application.
// - boot may go to test mode or to contactless protocol mode; here boot goes to test, system or halted mode only.
// - test or contactless mode can never return to boot mode.
// - after delivery, test mode can never be selected again.
// - boot mode exists only during start-up after a reset.
// - after start-up outside test, a set super bit means contactless mode only.
// - top 128 bytes of non-volatile memory form a protected row outside application space.
// - a 32-byte area is readable but never writable by application software.
// - a 16-byte area is writable until software locks it, then refused.
// - a 32-byte area lets each bit be set once and never cleared.
// - with card disable in use and set, every later application start is refused.
// - security fuses cannot be changed by any application software access.
// - factory identity area lies outside the row and has no access protection.
// - mode status word holds super and system bits; both clear is user mode.
// - software writes to the two mode bits can only clear them.
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pmg_top
(
   // clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RESETN,
   // ahb-lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // factory test strap from a pin
   input  wire logic        TEST_AVAIL,
   // cpu mode events
   input  wire logic        SVEC_CALL,
   input  wire logic        CVEC_CALL,
   input  wire logic        EXC_ENTRY,
   // mode and start-up results
   output pmg_pkg::pmg_mode_e MODE,
   output logic             SUPER_MODE_BIT,
   output logic             SYSTEM_MODE_BIT,
   output logic             APP_RUN,
   output logic             TEST_RUN,
   output logic             START_REFUSED,
   output logic [7:0]       SEC_CFG
);
   import pmg_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic [1:0]        tsync;
      logic              dph;
      logic              dph_wr;
      logic              dph_word;
      logic [ADDR_W-1:0] dph_addr;
      logic              rd_wait;
      logic [31:0]       rdata;
      logic              refused;
      pmg_mode_e         mode;
      logic              ssm;
      logic              sm;
      logic              app_run;
      logic              test_run;
      logic              start_refused;
      logic [7:0]        sec_cfg;
   } pmg_top_s;

   pmg_top_s      s;
   pmg_top_s      next_s;
   pmg_acc_s      acc;
   pmg_fuse_cfg_s cfg;
   pmg_mode_s     mst;
   logic [31:0]   mem_rdata;
   logic          mem_refused;
   logic          take;
   logic          row_hit;
   logic          id_hit;
   logic          mode_wr;
   logic [ADDR_W-1:0] a_addr;

   // ------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------
   pmg_mode_ctrl u_mode
   (
      .clk        (CORE_CLK),
      .rst_n      (RESETN),
      .test_avail (s.tsync[1]),
      .cfg        (cfg),
      .sw_wr      (mode_wr),
      .sw_keep    (HWDATA[1:0]),
      .svec_call  (SVEC_CALL),
      .cvec_call  (CVEC_CALL),
      .exc_entry  (EXC_ENTRY),
      .st         (mst)
   );

   pmg_fuse_row u_row
   (
      .clk        (CORE_CLK),
      .acc        (acc),
      .test_mode  (mst.mode == PMG_MODE_TEST),
      .rd_id      (s.dph_addr >= OFS_ID_BASE),
      .rd_word    (s.dph_addr[6:2]),
      .rd_data    (mem_rdata),
      .cfg        (cfg),
      .wr_refused (mem_refused)
   );

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // only whole words are served; narrower writes are ignored
   always_comb
   begin
      a_addr  = HADDR[ADDR_W-1:0];
      take    = HSEL && HTRANS[1] && HREADY;
      row_hit = s.dph_word && (s.dph_addr >= OFS_ROW_BASE) &&
                (s.dph_addr < OFS_ROW_BASE + 10'(ROW_BYTES));
      id_hit  = s.dph_word && (s.dph_addr >= OFS_ID_BASE) &&
                (s.dph_addr < OFS_ID_BASE + 10'(ID_BYTES));
      mode_wr = s.dph && s.dph_wr && s.dph_word && (s.dph_addr == OFS_MODE_STATUS);

      acc.wr     = s.dph && s.dph_wr && (row_hit || id_hit);
      acc.id_sel = id_hit;
      acc.word   = s.dph_addr[6:2];
      acc.wdata  = HWDATA;
      acc.wp_set = s.dph && s.dph_wr && s.dph_word && (s.dph_addr == OFS_ROW_CTRL) &&
                   HWDATA[CTL_WP_BIT];
      acc.cd_set = s.dph && s.dph_wr && s.dph_word && (s.dph_addr == OFS_ROW_CTRL) &&
                   HWDATA[CTL_CD_BIT];
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_s = s;

      // strap synchroniser; the first stage feeds only the second
      next_s.tsync = {s.tsync[0], TEST_AVAIL};

      // reads take one wait state so that a write just before has landed
      next_s.rd_wait = 1'b0;
      if (s.dph && !s.dph_wr && !s.rd_wait)
      begin
         next_s.rd_wait = 1'b1;
         next_s.rdata   = RESET_RDATA;
         if (!s.dph_word)
            next_s.rdata = RESET_RDATA;
         else if (s.dph_addr == OFS_MODE_STATUS)
            next_s.rdata = {25'h0, mst.mode, 2'h0, mst.system_mode_bit, mst.super_mode_bit};
         else if (s.dph_addr == OFS_START_STATUS)
            next_s.rdata = {26'h0, mst.start_refused, cfg.card_dis, cfg.card_feat,
                            cfg.delivered, s.tsync[1], mst.boot_done};
         else if (s.dph_addr == OFS_ROW_CTRL)
            next_s.rdata = {30'h0, cfg.card_dis, cfg.wp_lock};
         else if (s.dph_addr == OFS_GUARD_STATUS)
            next_s.rdata = {31'h0, s.refused};
         else if (row_hit || id_hit)
            next_s.rdata = mem_rdata;
      end

      // address phase capture; a read keeps the data phase open one more cycle
      if (s.dph && !s.dph_wr && !s.rd_wait)
      begin
         next_s.dph = 1'b1;
      end
      else
      begin
         next_s.dph      = take;
         next_s.dph_wr   = HWRITE;
         next_s.dph_word = (HSIZE == 3'h2) && (a_addr[1:0] == 2'h0);
         next_s.dph_addr = a_addr;
      end

      // sticky refused-write flag: a new refusal wins over the clear
      if (s.dph && s.dph_wr && s.dph_word && (s.dph_addr == OFS_GUARD_STATUS) && HWDATA[0])
         next_s.refused = 1'b0;
      if (acc.wr && mem_refused)
         next_s.refused = 1'b1;

      // registered views of the mode sequencer
      next_s.mode          = mst.mode;
      next_s.ssm           = mst.super_mode_bit;
      next_s.sm            = mst.system_mode_bit;
      next_s.app_run       = mst.boot_done && !mst.start_refused &&
                             (mst.mode != PMG_MODE_TEST);
      next_s.test_run      = (mst.mode == PMG_MODE_TEST);
      next_s.start_refused = mst.start_refused;
      next_s.sec_cfg       = cfg.sec_cfg;
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RESETN)
      begin
         s <= '{tsync: RESET_SYNC, dph: 1'b0, dph_wr: 1'b0, dph_word: 1'b0,
                dph_addr: '0, rd_wait: 1'b0, rdata: RESET_RDATA, refused: 1'b0,
                mode: PMG_MODE_BOOT, ssm: 1'b1, sm: 1'b0, app_run: 1'b0,
                test_run: 1'b0, start_refused: 1'b0, sec_cfg: 8'h00};
      end
      else
      begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_comb
   begin
      HREADYOUT       = !(s.dph && !s.dph_wr && !s.rd_wait);
      HRESP           = 1'b0;
      HRDATA          = s.rdata;
      MODE            = s.mode;
      SUPER_MODE_BIT  = s.ssm;
      SYSTEM_MODE_BIT = s.sm;
      APP_RUN         = s.app_run;
      TEST_RUN        = s.test_run;
      START_REFUSED   = s.start_refused;
      SEC_CFG         = s.sec_cfg;
   end
endmodule
`default_nettype wire

// ==== tb/pmg_properties.sv ====
// checker for the mode guard top level: start-up, mode bits and bus timing
// assumes it is bound onto pmg_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module pmg_properties
(
   // clock and reset
   input wire logic               CORE_CLK,
   input wire logic               RESETN,
   // bus
   input wire logic               HSEL,
   input wire logic [1:0]         HTRANS,
   input wire logic               HWRITE,
   input wire logic               HREADY,
   input wire logic               HREADYOUT,
   input wire logic               HRESP,
   // mode events and results
   input wire logic               SVEC_CALL,
   input wire logic               CVEC_CALL,
   input wire logic               EXC_ENTRY,
   input wire pmg_pkg::pmg_mode_e MODE,
   input wire logic               SUPER_MODE_BIT,
   input wire logic               SYSTEM_MODE_BIT,
   input wire logic               APP_RUN,
   input wire logic               TEST_RUN,
   input wire logic               START_REFUSED
);
   import pmg_pkg::*;
   logic [2:0] ev_age;
   logic       taken;

   // ------------------------------------------------------------
   // helper logic
   // ------------------------------------------------------------
   assign taken = HSEL && HTRANS[1] && HREADY;

   // cycles since the last mode event, saturating so old events never count
   always_ff @(posedge CORE_CLK)
   begin
      if (!RESETN)
         ev_age <= 3'h7;
      else if (SVEC_CALL || CVEC_CALL || EXC_ENTRY)
         ev_age <= 3'h0;
      else if (ev_age != 3'h7)
         ev_age <= ev_age + 3'h1;
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking dc @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESETN);

   sequence s_rd_req;
      taken && !HWRITE;
   endsequence
   sequence s_rd_wait;
      !HREADYOUT ##1 HREADYOUT;
   endsequence

   a_bus_okay: assert property (HRESP == 1'b0)
      else $error("bus response not okay");
   a_boot_first: assert property ($rose(RESETN) |-> MODE == PMG_MODE_BOOT)
      else $error("first mode after reset is not boot");
   a_boot_ends: assert property ($rose(RESETN) |-> ##[1:12] MODE != PMG_MODE_BOOT)
      else $error("boot mode did not end");
   a_no_return: assert property (MODE inside {PMG_MODE_TEST, PMG_MODE_CONTACTLESS}
      |=> MODE != PMG_MODE_BOOT)
      else $error("return into boot mode");
   a_boot_once: assert property (MODE != PMG_MODE_BOOT |=> MODE != PMG_MODE_BOOT)
      else $error("boot mode re-entered without reset");
   a_test_excl: assert property (TEST_RUN |-> !APP_RUN)
      else $error("test and application run together");
   a_refuse_halt: assert property (START_REFUSED |-> !APP_RUN && !SUPER_MODE_BIT
      && !SYSTEM_MODE_BIT)
      else $error("refused start still runs");
   a_user_mode: assert property ((APP_RUN && !SUPER_MODE_BIT && !SYSTEM_MODE_BIT) [*3]
      |-> MODE == PMG_MODE_USER)
      else $error("both bits clear but not user mode");
   a_super_cl: assert property ((APP_RUN && SUPER_MODE_BIT) [*3]
      |-> MODE == PMG_MODE_CONTACTLESS)
      else $error("super bit set but not contactless mode");
   a_bit_source: assert property (($rose(SUPER_MODE_BIT) || $rose(SYSTEM_MODE_BIT))
      && $past(APP_RUN, 2) |-> ev_age < 3'h4)
      else $error("mode bit set without a mode event");
   a_read_wait: assert property (s_rd_req |=> s_rd_wait)
      else $error("read wait state wrong");
   a_write_zero: assert property (taken && HWRITE |=> HREADYOUT)
      else $error("write not zero wait");
endmodule

bind pmg_top pmg_properties u_props
(
   .CORE_CLK(CORE_CLK), .RESETN(RESETN), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SVEC_CALL(SVEC_CALL),
   .CVEC_CALL(CVEC_CALL), .EXC_ENTRY(EXC_ENTRY), .MODE(MODE),
   .SUPER_MODE_BIT(SUPER_MODE_BIT), .SYSTEM_MODE_BIT(SYSTEM_MODE_BIT), .APP_RUN(APP_RUN),
   .TEST_RUN(TEST_RUN), .START_REFUSED(START_REFUSED)
);
`default_nettype wire

// ==== tb/pmg_top_bench.sv ====
// self-checking bench for the mode guard top level
// assumes pmg_top is the only slave; fuse contents persist across resets
`timescale 1ns/1ps
`default_nettype none
module pmg_top_bench;
   import pmg_pkg::*;
   logic        clk;
   logic        resetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hready;
   logic        test_avail;
   logic [2:0]  evt;
   pmg_mode_e   mode;
   logic        sup;
   logic        sys;
   logic        app_run;
   logic        test_run;
   logic        refused;
   logic [7:0]  sec_cfg;
   logic [31:0] rd;
   int          err_total;
   int          num_checks;
   int          cyc;

   pmg_top DUT
   (
      .CORE_CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(), .TEST_AVAIL(test_avail), .SVEC_CALL(evt[0]),
      .CVEC_CALL(evt[1]), .EXC_ENTRY(evt[2]), .MODE(mode), .SUPER_MODE_BIT(sup),
      .SYSTEM_MODE_BIT(sys), .APP_RUN(app_run), .TEST_RUN(test_run),
      .START_REFUSED(refused), .SEC_CFG(sec_cfg)
   );

   always #10 clk = ~clk;

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one whole-word transfer; the global timeout ends a hung wait
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   task automatic boot(input logic ta);
      @(posedge clk);
      test_avail <= ta;
      resetn     <= 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (int n = 0; n < 20 && mode === PMG_MODE_BOOT; n++)
         @(posedge clk);
   endtask

   // flags are super, system, app run, test run, start refused
   task automatic mchk(input pmg_mode_e m, input logic [4:0] f);
      repeat (4) @(posedge clk);
      #1;
      chk({24'h0, mode, sup, sys, app_run, test_run, refused}, {24'h0, m, f});
   endtask

   task automatic ev(input logic [2:0] e);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= 3'h0;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic s_test_program();
      boot(1'b1);
      mchk(PMG_MODE_TEST, 5'b10010);
      rdchk(32'h004, 32'h0000_0003);
      bus(1'b1, 32'h100, 32'hA5A5_0001);
      bus(1'b1, 32'h130, 32'h0000_00F0);
      // card feature and delivered fuses, security config 0x02
      bus(1'b1, 32'h150, 32'h0002_0300);
      rdchk(32'h150, 32'h0002_0300);
   endtask

   task automatic s_delivered();
      boot(1'b1);
      mchk(PMG_MODE_SYSTEM, 5'b01100);
   endtask

   task automatic s_row();
      bus(1'b1, 32'h100, 32'hFFFF_FFFF);
      rdchk(32'h100, 32'hA5A5_0001);
      rdchk(32'h00C, 32'h0000_0001);
      bus(1'b1, 32'h00C, 32'h0000_0001);
      rdchk(32'h00C, 32'h0000_0000);
      bus(1'b1, 32'h120, 32'h1234_5678);
      rdchk(32'h120, 32'h1234_5678);
      bus(1'b1, 32'h008, 32'h0000_0001);
      bus(1'b1, 32'h120, 32'h0000_0000);
      rdchk(32'h120, 32'h1234_5678);
      bus(1'b1, 32'h130, 32'h0000_000F);
      rdchk(32'h130, 32'h0000_00FF);
      bus(1'b1, 32'h130, 32'h0000_0000);
      rdchk(32'h130, 32'h0000_00FF);
      bus(1'b1, 32'h150, 32'hFFFF_FFFF);
      rdchk(32'h150, 32'h0002_0301);
      chk({24'h0, sec_cfg}, 32'h0000_0002);
      bus(1'b1, 32'h200, 32'hCAFE_0042);
      rdchk(32'h200, 32'hCAFE_0042);
      rdchk(32'h180, 32'h0000_0000);
   endtask

   task automatic s_modes();
      boot(1'b0);
      mchk(PMG_MODE_SYSTEM, 5'b01100);
      bus(1'b1, 32'h000, 32'h0000_0000);
      mchk(PMG_MODE_USER, 5'b00100);
      rdchk(32'h000, 32'h0000_0030);
      bus(1'b1, 32'h000, 32'h0000_0003);
      mchk(PMG_MODE_USER, 5'b00100);
      ev(3'h1);
      mchk(PMG_MODE_SYSTEM, 5'b01100);
      ev(3'h2);
      mchk(PMG_MODE_CONTACTLESS, 5'b11100);
      bus(1'b1, 32'h000, 32'h0000_0001);
      ev(3'h1);
      mchk(PMG_MODE_CONTACTLESS, 5'b10100);
      bus(1'b1, 32'h000, 32'h0000_0000);
      mchk(PMG_MODE_USER, 5'b00100);
      ev(3'h4);
      mchk(PMG_MODE_SYSTEM, 5'b01100);
   endtask

   task automatic s_card();
      bus(1'b1, 32'h008, 32'h0000_0002);
      rdchk(32'h008, 32'h0000_0003);
      boot(1'b0);
      mchk(PMG_MODE_HALTED, 5'b00001);
      rdchk(32'h004, 32'h0000_003D);
   endtask

   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   // whole run needs well under a thousand cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         err_total++;
         wrap_up();
      end
   end

   initial
   begin
      clk        = 1'b0;
      resetn     = 1'b0;
      hsel       = 1'b0;
      haddr      = 32'h0000_0000;
      htrans     = 2'h0;
      hwrite     = 1'b0;
      hwdata     = 32'h0000_0000;
      test_avail = 1'b0;
      evt        = 3'h0;
      s_test_program();
      s_delivered();
      s_row();
      s_modes();
      s_card();
      wrap_up();
   end
endmodule
`default_nettype wire
